// ### sim/cdr_dev_model.sv
// device model: register file, ack timing, shutdown status and off pins
`timescale 1ns/1ps
`default_nettype none
module cdr_dev_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // test knobs
  input  wire logic [3:0]  ack_dly_i,
  input  wire logic [9:0]  off_dly_i,
  input  wire logic        pin_en_i,
  // register port
  input  wire logic        dev_wr_i,
  input  wire logic        dev_rd_i,
  input  wire logic [15:0] dev_addr_i,
  input  wire logic [15:0] dev_wdata_i,
  output logic             dev_ack_o,
  output logic [15:0]      dev_rdata_o,
  // off indications and host misuse count
  output logic             main_off_pin_o,
  output logic             async_off_pin_o,
  output logic [7:0]       bad_o
);
  logic [15:0] regs_ff [0:63];
  logic [3:0]  wait_ff;
  logic [9:0]  main_cnt_ff;
  logic [9:0]  async_cnt_ff;
  logic        main_off_ff;
  logic        async_off_ff;
  logic        go;
  logic        wr_now;
  logic [5:0]  idx;

  assign idx    = dev_addr_i[5:0];
  assign go     = (dev_wr_i | dev_rd_i) & ~dev_ack_o;
  assign wr_now = dev_wr_i & go & (wait_ff == ack_dly_i);
  assign main_off_pin_o  = pin_en_i & main_off_ff;
  assign async_off_pin_o = pin_en_i & async_off_ff;

  // handshake and register file; released data bus toggles
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dev_ack_o   <= 1'b0;
      dev_rdata_o <= 16'h0000;
      wait_ff     <= 4'h0;
      for (int i = 0; i < 64; i++) regs_ff[i] <= 16'h0000;
    end else begin
      dev_ack_o   <= 1'b0;
      dev_rdata_o <= ~dev_rdata_o;
      if (go && wait_ff != ack_dly_i) begin
        wait_ff <= wait_ff + 4'h1;
      end else if (go) begin
        dev_ack_o <= 1'b1;
        wait_ff   <= 4'h0;
        if (dev_rd_i) dev_rdata_o <= (idx == 6'h30) ?
          {14'h0000, async_off_ff, main_off_ff} : regs_ff[idx];
        if (dev_wr_i) regs_ff[idx] <= dev_wdata_i;
      end
    end
  end

  // domain shutdown with delayed off status
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      main_off_ff  <= 1'b1;
      async_off_ff <= 1'b1;
      main_cnt_ff  <= 10'h000;
      async_cnt_ff <= 10'h000;
      bad_o        <= 8'h00;
    end else begin
      if (main_cnt_ff != 10'h000) main_cnt_ff <= main_cnt_ff - 10'h001;
      if (main_cnt_ff == 10'h001) main_off_ff <= 1'b1;
      if (async_cnt_ff != 10'h000) async_cnt_ff <= async_cnt_ff - 10'h001;
      if (async_cnt_ff == 10'h001) async_off_ff <= 1'b1;
      if (wr_now && (main_cnt_ff != 10'h000 || async_cnt_ff != 10'h000))
        bad_o <= bad_o + 8'h01;
      if (wr_now && idx == 6'h01) begin
        if (dev_wdata_i[0]) main_off_ff <= 1'b0;
        else main_cnt_ff <= off_dly_i;
        if (!dev_wdata_i[0] && regs_ff[6'h05] != 16'h0000)
          bad_o <= bad_o + 8'h01;
      end
      if (wr_now && idx == 6'h11) begin
        if (dev_wdata_i[0]) async_off_ff <= 1'b0;
        else async_cnt_ff <= off_dly_i;
        if (!dev_wdata_i[0] && regs_ff[6'h15] != 16'h0000)
          bad_o <= bad_o + 8'h01;
      end
    end
  end
endmodule : cdr_dev_model
`default_nettype wire

// ### sim/clock_domain_rate_detect_test.sv
// self-checking bench for the clock controller with device model
`timescale 1ns/1ps
`default_nettype none
module clock_domain_rate_detect_test
  import cdr_pkg::*;
;
  logic        clk_i, rst_b_i, cmd_valid_i, src_ready_i;
  cdr_op_t     cmd_op_i;
  logic        cmd_ready_o, cmd_done_o, cmd_err_o;
  logic [3:0]  main_src_i, async_src_i, ack_dly;
  logic [2:0]  main_freq_i, async_freq_i;
  logic        main_frac_i, det_enable_i, det_policy_i, pin_en;
  logic [14:0] main_rates_i;
  logic [9:0]  async_rates_i, off_dly;
  logic [1:0]  det_sel_i;
  logic [19:0] det_rates_i;
  logic        main_on_o, async_on_o, dev_wr_o, dev_rd_o, dev_ack;
  logic [15:0] dev_addr_o, dev_wdata_o, dev_rdata;
  logic        main_pin, async_pin;
  logic [7:0]  bad;
  int          num_errors = 0;
  int          checked = 0;

  cdr_ctrl dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o),
    .cmd_err_o(cmd_err_o), .src_ready_i(src_ready_i),
    .main_src_i(main_src_i), .main_freq_i(main_freq_i),
    .main_frac_i(main_frac_i), .main_rates_i(main_rates_i),
    .async_src_i(async_src_i), .async_freq_i(async_freq_i),
    .async_rates_i(async_rates_i), .det_enable_i(det_enable_i),
    .det_sel_i(det_sel_i), .det_policy_i(det_policy_i),
    .det_rates_i(det_rates_i), .main_on_o(main_on_o),
    .async_on_o(async_on_o), .dev_wr_o(dev_wr_o), .dev_rd_o(dev_rd_o),
    .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o),
    .dev_ack_i(dev_ack), .dev_rdata_i(dev_rdata),
    .main_off_pin_i(main_pin), .async_off_pin_i(async_pin));

  cdr_dev_model dev_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .ack_dly_i(ack_dly), .off_dly_i(off_dly), .pin_en_i(pin_en),
    .dev_wr_i(dev_wr_o), .dev_rd_i(dev_rd_o), .dev_addr_i(dev_addr_o),
    .dev_wdata_i(dev_wdata_o), .dev_ack_o(dev_ack),
    .dev_rdata_o(dev_rdata), .main_off_pin_o(main_pin),
    .async_off_pin_o(async_pin), .bad_o(bad));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask : chk1

  // offer one command; watch for refusal or completion
  task automatic run_cmd(input cdr_op_t op, input logic exp_err,
                         input int lim);
    int   n;
    logic err_seen;
    logic done_seen;
    err_seen = 1'b0;
    done_seen = 1'b0;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      #1 n++;
    end
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    @(posedge clk_i);
    #1 cmd_valid_i = 1'b0;
    for (n = 0; n < lim && !done_seen; n++) begin
      err_seen |= (cmd_err_o === 1'b1);
      done_seen = (cmd_done_o === 1'b1);
      if (!done_seen) @(posedge clk_i);
      if (!done_seen) #1;
    end
    chk1(err_seen, exp_err);
    chk1(done_seen, ~exp_err);
  endtask : run_cmd

  task automatic s_main;
    main_src_i = 4'h4;
    main_freq_i = 3'h3;
    main_frac_i = 1'b1;
    main_rates_i = {5'h09, 5'h0d, 5'h0c};
    run_cmd(CDR_OP_MAIN_CFG, 1'b0, 100);
    chk16(dev_u.regs_ff[6'h00], 16'h8403);
    main_frac_i = 1'b0;
    main_rates_i = {5'h01, 5'h04, 5'h00};
    run_cmd(CDR_OP_MAIN_CFG, 1'b1, 4);
    main_rates_i = {5'h01, 5'h04, 5'h14};
    run_cmd(CDR_OP_MAIN_CFG, 1'b1, 4);
    main_rates_i = {5'h01, 5'h0c, 5'h13};
    run_cmd(CDR_OP_MAIN_CFG, 1'b1, 4);
    main_rates_i = {5'h01, 5'h04, 5'h13};
    run_cmd(CDR_OP_MAIN_CFG, 1'b0, 100);
    chk16(dev_u.regs_ff[6'h00], 16'h0403);
    chk16(dev_u.regs_ff[6'h02], 16'h0013);
    chk16(dev_u.regs_ff[6'h03], 16'h0004);
    chk16(dev_u.regs_ff[6'h04], 16'h0001);
    run_cmd(CDR_OP_MAIN_EN, 1'b1, 4);
    chk1(main_on_o, 1'b0);
    src_ready_i = 1'b1;
    run_cmd(CDR_OP_MAIN_EN, 1'b0, 50);
    chk1(main_on_o, 1'b1);
    chk16(dev_u.regs_ff[6'h01], 16'h0001);
    run_cmd(CDR_OP_MAIN_CFG, 1'b1, 4);
    run_cmd(CDR_OP_MAIN_EN, 1'b1, 4);
  endtask : s_main

  task automatic s_det;
    logic [19:0] bad_set [3];
    bad_set = '{{5'h01, 5'h02, 5'h03, 5'h01}, {5'h05, 5'h0d, 5'h01, 5'h02},
                {5'h04, 5'h0c, 5'h01, 5'h02}};
    det_enable_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      det_rates_i = bad_set[i];
      run_cmd(CDR_OP_DET_CFG, 1'b1, 4);
    end
    det_rates_i = {5'h01, 5'h0d, 5'h04, 5'h03};
    for (int i = 0; i < 2; i++) begin
      det_policy_i = i[0];
      det_sel_i = 2'h2 + i[1:0];
      run_cmd(CDR_OP_DET_CFG, 1'b0, 100);
      chk16(dev_u.regs_ff[6'h20], i ? 16'h0131 : 16'h0021);
    end
    chk16(dev_u.regs_ff[6'h21], 16'h0003);
    chk16(dev_u.regs_ff[6'h24], 16'h0001);
  endtask : s_det

  task automatic s_main_off;
    ack_dly = 4'h3;
    off_dly = 10'd350;
    run_cmd(CDR_OP_MAIN_DIS, 1'b0, 2000);
    chk1(dev_u.main_off_ff, 1'b1);
    chk16(dev_u.regs_ff[6'h01], 16'h0000);
    chk1(main_on_o, 1'b0);
    chk16({8'h00, bad}, 16'h0000);
    chk1(async_on_o, 1'b0);
    run_cmd(CDR_OP_MAIN_DIS, 1'b1, 4);
  endtask : s_main_off

  task automatic s_async;
    async_src_i = 4'h5;
    async_freq_i = 3'h2;
    async_rates_i = {5'h09, 5'h14};
    run_cmd(CDR_OP_ASYNC_CFG, 1'b1, 4);
    async_rates_i = {5'h09, 5'h0b};
    run_cmd(CDR_OP_ASYNC_CFG, 1'b0, 100);
    chk16(dev_u.regs_ff[6'h10], 16'h0502);
    chk16(dev_u.regs_ff[6'h12], 16'h000b);
    chk16(dev_u.regs_ff[6'h13], 16'h0009);
    src_ready_i = 1'b0;
    run_cmd(CDR_OP_ASYNC_EN, 1'b1, 4);
    src_ready_i = 1'b1;
    run_cmd(CDR_OP_ASYNC_EN, 1'b0, 50);
    chk1(async_on_o, 1'b1);
    pin_en = 1'b1;
    off_dly = 10'd600;
    run_cmd(CDR_OP_ASYNC_DIS, 1'b0, 2000);
    chk1(dev_u.async_off_ff, 1'b1);
    chk1(async_on_o, 1'b0);
    chk16({8'h00, bad}, 16'h0000);
  endtask : s_async

  task automatic complete_run;
    $display("errors=%0d checked=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end

  initial begin
    {rst_b_i, cmd_valid_i, src_ready_i, main_frac_i, pin_en} = 5'h00;
    {det_enable_i, det_policy_i, det_sel_i, det_rates_i} = '0;
    cmd_op_i = CDR_OP_MAIN_CFG;
    {main_src_i, main_freq_i, main_rates_i} = '0;
    {async_src_i, async_freq_i, async_rates_i} = '0;
    ack_dly = 4'h0;
    off_dly = 10'd4;
    repeat (4) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    chk1(cmd_ready_o, 1'b1);
    chk1(dev_wr_o | dev_rd_o | main_on_o | async_on_o, 1'b0);
    s_main();
    s_det();
    s_main_off();
    s_async();
    complete_run();
  end
endmodule : clock_domain_rate_detect_test
`default_nettype wire

// ### verilog/cdr_ctrl.sv
// host controller for the codec clock domains and rate detector
// Notes on behaviour
// - never program one rate into two detect-rate fields
// - never pair 192k with 176.4k, nor 96k with 88.2k
// - frequency code and fraction match source; rates from one family (only the rates are checked, against the fraction)
// - enable source before main enable; reconfigure only while disabled
// - disable main-domain functions before clearing main enable
// - after clearing main enable, no writes until off status seen
// - async source and code match (not checked); source enabled before async enable
// - disable async-domain functions before clearing async enable
// - after clearing async enable, no writes until off status seen
// - keep async clock off when all rates follow the main clock; the controller does not check this
`timescale 1ns/1ps
`default_nettype none
`include "cdr_map.svh"
module cdr_ctrl
  import cdr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // user command port
  input  wire logic        cmd_valid_i,
  input  wire cdr_op_t     cmd_op_i,
  output logic             cmd_ready_o,
  output logic             cmd_done_o,
  output logic             cmd_err_o,
  input  wire logic        src_ready_i,
  // main domain settings
  input  wire logic [3:0]  main_src_i,
  input  wire logic [2:0]  main_freq_i,
  input  wire logic        main_frac_i,
  input  wire logic [14:0] main_rates_i,
  // async domain settings
  input  wire logic [3:0]  async_src_i,
  input  wire logic [2:0]  async_freq_i,
  input  wire logic [9:0]  async_rates_i,
  // rate detector settings
  input  wire logic        det_enable_i,
  input  wire logic [1:0]  det_sel_i,
  input  wire logic        det_policy_i,
  input  wire logic [19:0] det_rates_i,
  // domain state
  output logic             main_on_o,
  output logic             async_on_o,
  // device register port
  output logic             dev_wr_o,
  output logic             dev_rd_o,
  output logic [15:0]      dev_addr_o,
  output logic [15:0]      dev_wdata_o,
  input  wire logic        dev_ack_i,
  input  wire logic [15:0] dev_rdata_i,
  // device off-status pins
  input  wire logic        main_off_pin_i,
  input  wire logic        async_off_pin_i
);

  // bit 1: duplicate, bit 0: forbidden pair
  function automatic logic [1:0] det_check(input logic [19:0] r);
    logic dup;
    logic pair;
    logic [3:0] h192, h176, h96, h88;
    dup = 1'b0;
    for (int i = 0; i < 4; i++) begin
      for (int j = i + 1; j < 4; j++) begin
        if (r[i*5 +: 5] == r[j*5 +: 5]) dup = 1'b1;
      end
      h192[i] = (r[i*5 +: 5] == `CDR_RATE_192K);
      h176[i] = (r[i*5 +: 5] == `CDR_RATE_176K4);
      h96[i]  = (r[i*5 +: 5] == `CDR_RATE_96K);
      h88[i]  = (r[i*5 +: 5] == `CDR_RATE_88K2);
    end
    pair = ((|h192) && (|h176)) || ((|h96) && (|h88));
    return {dup, pair};
  endfunction : det_check

  function automatic logic in_range(input logic [4:0] c);
    return (c >= `CDR_RATE_MIN) && (c <= `CDR_RATE_MAX);
  endfunction : in_range

  cdr_state_t  state_ff;
  logic [31:0] step_ff [0:5];
  logic [2:0]  step_cnt_ff;
  logic [2:0]  step_idx_ff;
  logic        wait_off_ff;
  logic        wait_async_ff;
  logic        main_on_ff;
  logic        async_on_ff;
  logic        err_ff;
  logic [15:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [7:0]  gap_ff;
  logic        main_off_sync;
  logic        async_off_sync;
  logic        cmd_ok;
  logic        accept;
  logic        off_seen;
  logic [15:0] main_cfg;
  logic [15:0] async_cfg;
  logic [15:0] det_ctrl;

  // main-off and async-off pins from the device
  cdr_sync2 u_main_off_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (main_off_pin_i),
    .q_o     (main_off_sync)
  );
  cdr_sync2 u_async_off_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (async_off_pin_i),
    .q_o     (async_off_sync)
  );

  // register words
  assign main_cfg = (16'(main_src_i) << `CDR_CFG_SRC_LSB)
                  | (16'(main_freq_i) << `CDR_CFG_FREQ_LSB)
                  | (16'(main_frac_i) << `CDR_CFG_FRAC_BIT);
  assign async_cfg = (16'(async_src_i) << `CDR_CFG_SRC_LSB)
                   | (16'(async_freq_i) << `CDR_CFG_FREQ_LSB);
  assign det_ctrl = (16'(det_enable_i) << `CDR_DET_EN_BIT)
                  | (16'(det_sel_i) << `CDR_DET_SEL_LSB)
                  | (16'(det_policy_i) << `CDR_DET_POL_BIT);

  // command legality
  always_comb begin
    cmd_ok = 1'b0;
    case (cmd_op_i)
      CDR_OP_MAIN_CFG: begin
        cmd_ok = !main_on_ff;
        for (int i = 0; i < 3; i++) begin
          if (!in_range(main_rates_i[i*5 +: 5])) cmd_ok = 1'b0;
          if (main_rates_i[i*5 + `CDR_RATE_FAM_BIT] != main_frac_i)
            cmd_ok = 1'b0;
        end
      end
      CDR_OP_MAIN_EN:   cmd_ok = src_ready_i && !main_on_ff;
      CDR_OP_MAIN_DIS:  cmd_ok = main_on_ff;
      CDR_OP_ASYNC_CFG: cmd_ok = !async_on_ff
                               && in_range(async_rates_i[4:0])
                               && in_range(async_rates_i[9:5]);
      CDR_OP_ASYNC_EN:  cmd_ok = src_ready_i && !async_on_ff;
      CDR_OP_ASYNC_DIS: cmd_ok = async_on_ff;
      CDR_OP_DET_CFG: begin
        cmd_ok = (det_check(det_rates_i) == 2'b00);
        for (int i = 0; i < 4; i++) begin
          if (!in_range(det_rates_i[i*5 +: 5])) cmd_ok = 1'b0;
        end
      end
      default: cmd_ok = 1'b0;
    endcase
  end

  assign cmd_ready_o = (state_ff == CDR_ST_IDLE);
  assign accept      = cmd_ready_o && cmd_valid_i && cmd_ok;
  assign off_seen    = wait_async_ff
                     ? (dev_rdata_i[`CDR_STS_ASYNC_OFF] || async_off_sync)
                     : (dev_rdata_i[`CDR_STS_MAIN_OFF] || main_off_sync);

  // write list built when a command is taken
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 6; i++) step_ff[i] <= 32'h0000_0000;
      step_cnt_ff   <= 3'h0;
      wait_off_ff   <= 1'b0;
      wait_async_ff <= 1'b0;
    end else if (accept) begin
      wait_off_ff   <= 1'b0;
      wait_async_ff <= 1'b0;
      case (cmd_op_i)
        CDR_OP_MAIN_CFG: begin
          step_ff[0] <= {`CDR_REG_MAIN_CFG, main_cfg};
          for (int i = 0; i < 3; i++)
            step_ff[i+1] <= {`CDR_REG_MAIN_RATE0 + 16'(i),
                             11'h000, main_rates_i[i*5 +: 5]};
          step_cnt_ff <= 3'h4;
        end
        CDR_OP_MAIN_EN: begin
          step_ff[0]  <= {`CDR_REG_MAIN_EN, 16'h0001};
          step_cnt_ff <= 3'h1;
        end
        CDR_OP_MAIN_DIS: begin
          step_ff[0]  <= {`CDR_REG_MAIN_FUNC, 16'h0000};
          step_ff[1]  <= {`CDR_REG_MAIN_EN, 16'h0000};
          step_cnt_ff <= 3'h2;
          wait_off_ff <= 1'b1;
        end
        CDR_OP_ASYNC_CFG: begin
          step_ff[0] <= {`CDR_REG_ASYNC_CFG, async_cfg};
          for (int i = 0; i < 2; i++)
            step_ff[i+1] <= {`CDR_REG_ASYNC_RATE0 + 16'(i),
                             11'h000, async_rates_i[i*5 +: 5]};
          step_cnt_ff <= 3'h3;
        end
        CDR_OP_ASYNC_EN: begin
          step_ff[0]  <= {`CDR_REG_ASYNC_EN, 16'h0001};
          step_cnt_ff <= 3'h1;
        end
        CDR_OP_ASYNC_DIS: begin
          step_ff[0]    <= {`CDR_REG_ASYNC_FUNC, 16'h0000};
          step_ff[1]    <= {`CDR_REG_ASYNC_EN, 16'h0000};
          step_cnt_ff   <= 3'h2;
          wait_off_ff   <= 1'b1;
          wait_async_ff <= 1'b1;
        end
        default: begin
          for (int i = 0; i < 4; i++)
            step_ff[i] <= {`CDR_REG_DET_RATE0 + 16'(i),
                           11'h000, det_rates_i[i*5 +: 5]};
          step_ff[4]  <= {`CDR_REG_DET_CTRL, det_ctrl};
          step_cnt_ff <= 3'h5;
        end
      endcase
    end
  end

  // sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_ff    <= CDR_ST_IDLE;
      step_idx_ff <= 3'h0;
      addr_ff     <= 16'h0000;
      wdata_ff    <= 16'h0000;
      gap_ff      <= 8'h00;
    end else begin
      case (state_ff)
        CDR_ST_IDLE: begin
          step_idx_ff <= 3'h0;
          if (accept) state_ff <= CDR_ST_NEXT;
        end
        CDR_ST_NEXT: begin
          if (step_idx_ff == step_cnt_ff) begin
            addr_ff  <= `CDR_REG_STATUS;
            state_ff <= wait_off_ff ? CDR_ST_POLL : CDR_ST_DONE;
          end else begin
            addr_ff  <= step_ff[step_idx_ff][31:16];
            wdata_ff <= step_ff[step_idx_ff][15:0];
            state_ff <= CDR_ST_WRITE;
          end
        end
        CDR_ST_WRITE: begin
          if (dev_ack_i) begin
            step_idx_ff <= step_idx_ff + 3'h1;
            state_ff    <= CDR_ST_NEXT;
          end
        end
        CDR_ST_POLL: begin
          if (dev_ack_i) begin
            gap_ff   <= 8'(`CDR_POLL_GAP_CYC);
            state_ff <= off_seen ? CDR_ST_DONE : CDR_ST_GAP;
          end
        end
        CDR_ST_GAP: begin
          if (wait_async_ff ? async_off_sync : main_off_sync)
            state_ff <= CDR_ST_DONE;
          else if (gap_ff == 8'h00)
            state_ff <= CDR_ST_POLL;
          else
            gap_ff <= gap_ff - 8'h01;
        end
        CDR_ST_DONE: state_ff <= CDR_ST_IDLE;
        default:     state_ff <= CDR_ST_IDLE;
      endcase
    end
  end

  // domain state and refusal flag
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      main_on_ff  <= 1'b0;
      async_on_ff <= 1'b0;
      err_ff      <= 1'b0;
    end else begin
      err_ff <= cmd_ready_o && cmd_valid_i && !cmd_ok;
      if (state_ff == CDR_ST_WRITE && dev_ack_i) begin
        if (addr_ff == `CDR_REG_MAIN_EN) main_on_ff <= wdata_ff[0];
        if (addr_ff == `CDR_REG_ASYNC_EN) async_on_ff <= wdata_ff[0];
      end
    end
  end

  assign dev_wr_o    = (state_ff == CDR_ST_WRITE);
  assign dev_rd_o    = (state_ff == CDR_ST_POLL);
  assign dev_addr_o  = addr_ff;
  assign dev_wdata_o = wdata_ff;
  assign cmd_done_o  = (state_ff == CDR_ST_DONE);
  assign cmd_err_o   = err_ff;
  assign main_on_o   = main_on_ff;
  assign async_on_o  = async_on_ff;

  // checking helpers
  logic [15:0] prev_addr_ff;
  logic        src_ok_ff;
  logic        frac_ff;
  logic [19:0] det_rates_ff;
  logic [1:0]  det_viol;
  assign det_viol = det_check(det_rates_ff);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      prev_addr_ff <= 16'h0000;
      src_ok_ff    <= 1'b0;
      frac_ff      <= 1'b0;
      det_rates_ff <= 20'h00000;
    end else begin
      if (dev_wr_o && dev_ack_i) prev_addr_ff <= dev_addr_o;
      if (accept) begin
        src_ok_ff    <= src_ready_i;
        frac_ff      <= main_frac_i;
        det_rates_ff <= det_rates_i;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_wait_no_write: assert property (
    (state_ff == CDR_ST_POLL || state_ff == CDR_ST_GAP)
    |-> !dev_wr_o && dev_addr_o == `CDR_REG_STATUS)
    else $error("write issued while waiting for clock off");
  a_async_off_hold: assert property (
    dev_wr_o && dev_ack_i && dev_addr_o == `CDR_REG_ASYNC_EN
    && dev_wdata_o == 16'h0000 |=> !dev_wr_o [*3])
    else $error("write followed async disable too soon");
  a_main_func_first: assert property (
    dev_wr_o && dev_addr_o == `CDR_REG_MAIN_EN && dev_wdata_o == 16'h0000
    |-> prev_addr_ff == `CDR_REG_MAIN_FUNC)
    else $error("main enable cleared before functions off");
  a_async_func_first: assert property (
    dev_wr_o && dev_addr_o == `CDR_REG_ASYNC_EN && dev_wdata_o == 16'h0000
    |-> prev_addr_ff == `CDR_REG_ASYNC_FUNC)
    else $error("async enable cleared before functions off");
  a_main_en_src: assert property (
    dev_wr_o && dev_addr_o == `CDR_REG_MAIN_EN && dev_wdata_o[0]
    |-> src_ok_ff && !main_on_ff)
    else $error("main enable set without ready source");
  a_async_en_src: assert property (
    dev_wr_o && dev_addr_o == `CDR_REG_ASYNC_EN && dev_wdata_o[0]
    |-> src_ok_ff)
    else $error("async enable set without ready source");
  a_det_no_dup: assert property (
    dev_wr_o && dev_addr_o == `CDR_REG_DET_CTRL
    |-> !det_viol[1])
    else $error("duplicate detect rate programmed");
  a_det_no_pair: assert property (
    dev_wr_o && dev_addr_o == `CDR_REG_DET_CTRL
    |-> !det_viol[0])
    else $error("forbidden detect rate pair programmed");
  a_rate_family: assert property (
    dev_wr_o && dev_addr_o >= `CDR_REG_MAIN_RATE0
    && dev_addr_o < `CDR_REG_MAIN_FUNC
    |-> dev_wdata_o[`CDR_RATE_FAM_BIT] == frac_ff)
    else $error("main rate outside chosen family");

  c_main_shutdown: cover property (
    state_ff == CDR_ST_POLL && !wait_async_ff ##[1:300] cmd_done_o);
  c_async_shutdown: cover property (
    state_ff == CDR_ST_GAP && wait_async_ff ##[1:300] cmd_done_o);
  c_det_config: cover property (
    dev_wr_o && dev_ack_i && dev_addr_o == `CDR_REG_DET_CTRL);
  c_refused: cover property (cmd_err_o);

endmodule : cdr_ctrl
`default_nettype wire

// ### verilog/cdr_map.svh
// register offsets, field positions and timing counts for the clock controller
`ifndef CDR_MAP_SVH
`define CDR_MAP_SVH

// main domain registers
`define CDR_REG_MAIN_CFG    16'h0100
`define CDR_REG_MAIN_EN     16'h0101
`define CDR_REG_MAIN_RATE0  16'h0102
`define CDR_REG_MAIN_FUNC   16'h0105
// async domain registers
`define CDR_REG_ASYNC_CFG   16'h0110
`define CDR_REG_ASYNC_EN    16'h0111
`define CDR_REG_ASYNC_RATE0 16'h0112
`define CDR_REG_ASYNC_FUNC  16'h0115
// rate detector registers
`define CDR_REG_DET_CTRL    16'h0120
`define CDR_REG_DET_RATE0   16'h0121
// status register and its bits
`define CDR_REG_STATUS      16'h0130
`define CDR_STS_MAIN_OFF    0
`define CDR_STS_ASYNC_OFF   1

// clock config fields
`define CDR_CFG_FREQ_LSB    0
`define CDR_CFG_SRC_LSB     8
`define CDR_CFG_FRAC_BIT    15
// detector control fields
`define CDR_DET_EN_BIT      0
`define CDR_DET_SEL_LSB     4
`define CDR_DET_POL_BIT     8

// rate codes; bit 3 marks the 44.1 kHz family
`define CDR_RATE_MIN        5'h01
`define CDR_RATE_MAX        5'h13
`define CDR_RATE_FAM_BIT    3
`define CDR_RATE_192K       5'h05
`define CDR_RATE_176K4      5'h0d
`define CDR_RATE_96K        5'h04
`define CDR_RATE_88K2       5'h0c

// status poll spacing
`define CDR_CLK_PERIOD_NS   10
`define CDR_POLL_GAP_NS     1000
`define CDR_POLL_GAP_CYC    (`CDR_POLL_GAP_NS / `CDR_CLK_PERIOD_NS)

`endif

// ### verilog/cdr_pkg.sv
// types for the clock controller
`default_nettype none
package cdr_pkg;

  typedef enum logic [2:0] {
    CDR_OP_MAIN_CFG  = 3'b000,
    CDR_OP_MAIN_EN   = 3'b001,
    CDR_OP_MAIN_DIS  = 3'b010,
    CDR_OP_ASYNC_CFG = 3'b011,
    CDR_OP_ASYNC_EN  = 3'b100,
    CDR_OP_ASYNC_DIS = 3'b101,
    CDR_OP_DET_CFG   = 3'b110
  } cdr_op_t;

  typedef enum logic [2:0] {
    CDR_ST_IDLE  = 3'b000,
    CDR_ST_NEXT  = 3'b001,
    CDR_ST_WRITE = 3'b010,
    CDR_ST_POLL  = 3'b011,
    CDR_ST_GAP   = 3'b100,
    CDR_ST_DONE  = 3'b101
  } cdr_state_t;

endpackage : cdr_pkg
`default_nettype wire

// ### verilog/cdr_sync2.sv
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps
`default_nettype none
module cdr_sync2 (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // pin and synchronised level
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule : cdr_sync2
`default_nettype wire
